/* rtl/area_timing_pkg.sv */
// Package: register map, field layout, reset values and shared types of the area timing block
package area_timing_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register byte offsets (one aligned 32-bit word each)
    localparam logic [7:0] area2_wait_control_off = 8'h00;
    localparam logic [7:0] area_config_off = 8'h04;
    localparam logic [7:0] sdram_timing_off = 8'h08;
    localparam logic [7:0] status_off = 8'h0C;

    ////////////////////////////////////////////////////////////////////////////////
    // Area-2 wait control, SDRAM mode
    localparam int cas_lsb = 7;                         // Area-3 CAS latency field, bits 8:7
    localparam int fixed_one_bit = 10;                  // Reads as one
    localparam logic [1:0] cas_reset = 2'h2;            // Three cycles after reset

    // Own area configuration register
    localparam int area2_type_lsb = 0;
    localparam int area3_type_lsb = 2;
    localparam int area2_hold_lsb = 4;
    localparam int area3_hold_lsb = 6;
    localparam logic [7:0] area_config_reset = 8'h00;  // Normal space, 0.5 cycle hold

    // Shared SDRAM timing register
    localparam int precharge_lsb = 0;
    localparam int ras_to_cas_lsb = 2;
    localparam int write_precharge_lsb = 4;
    localparam int refresh_recovery_lsb = 6;
    localparam logic [7:0] sdram_timing_reset = 8'h00;

    // Status register bits
    localparam int placement_error_bit = 0;
    localparam int area2_type_error_bit = 1;
    localparam int access_busy_bit = 2;

    // AHB encodings
    localparam logic [2:0] hsize_word = 3'h2;
    localparam logic [1:0] htrans_nonseq_bit = 2'h2;

    // Access engine defaults
    localparam int strobe_cycles_default = 2;

    ////////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        area_normal,
        area_sram_byte,
        area_sdram,
        area_reserved
    } area_type_e;

    // Effective SDRAM timing applied to one area
    typedef struct packed {
        logic [1:0] precharge_wait;
        logic [1:0] ras_to_cas_wait;
        logic [1:0] write_precharge_wait;
        logic [1:0] refresh_recovery_wait;
        logic [1:0] cas_latency_cycles;     // 1, 2 or 3
    } sdram_timing_s;

endpackage

/* rtl/sdram_area_timing_config.sv */
// Top: AHB-Lite register file, shared SDRAM timing for areas 2 and 3, and strobe hold engine
//
// The register offsets and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

module sdram_area_timing_config #(
    parameter int addr_w = 24,                                   // External address width
    parameter int strobe_cycles = area_timing_pkg::strobe_cycles_default
) (
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Access request from the bus controller core
    input wire logic access_req,
    input wire logic access_area,                  // 0 area 2, 1 area 3
    input wire logic access_write,
    input wire logic [addr_w-1:0] access_addr,
    output logic access_ack,
    // External memory pins
    output logic [addr_w-1:0] ext_addr,
    output logic ext_addr_valid,
    output logic [1:0] chip_select_n,              // Index 0 area 2, index 1 area 3
    output logic read_strobe_n,
    output logic write_strobe_n,
    // Effective configuration towards the SDRAM sequencer
    output logic area2_sdram_en,
    output logic area3_sdram_en,
    output area_timing_pkg::sdram_timing_s area2_timing,
    output area_timing_pkg::sdram_timing_s area3_timing
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations
    typedef enum logic [1:0] {
        st_idle,
        st_strobe,
        st_hold
    } access_state_e;

    localparam int cnt_w = (strobe_cycles > 1) ? $clog2(strobe_cycles) : 1;
    localparam logic [cnt_w-1:0] strobe_last = cnt_w'(strobe_cycles - 1);

    logic [1:0] cas_q;               // Area-3 CAS latency code
    logic [7:0] area_config_q;       // Area types and hold codes
    logic [7:0] sdram_timing_q;      // The one shared timing copy
    logic wr_pend_q;                 // Write data phase pending
    logic rd_pend_q;                 // Read data phase pending
    logic [7:0] addr_q;              // Latched offset of the data phase
    access_state_e state_q;
    logic [cnt_w-1:0] strobe_cnt_q;
    logic area_q;                    // Area of the access in flight
    logic write_q;
    logic hold_start;
    logic hold_keep;
    logic hold_busy;
    logic [1:0] hold_code;
    logic [31:0] rd_word;
    area_timing_pkg::area_type_e area2_type;
    area_timing_pkg::area_type_e area3_type;
    area_timing_pkg::sdram_timing_s shared_timing;
    logic placement_error;
    logic area2_type_error;
    logic addr_phase;

    ////////////////////////////////////////////////////////////////////////////////
    // AHB-Lite address phase capture
    // Zero-wait slave; only whole-word writes are acted on, reads of any size are answered
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign addr_phase = hsel & hready & htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 8'h00;
        end else if (hready) begin
            wr_pend_q <= addr_phase & hwrite & (hsize == area_timing_pkg::hsize_word);
            rd_pend_q <= addr_phase & ~hwrite;
            addr_q <= haddr[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Area-2 wait control register: only the CAS latency field is stored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cas_q <= area_timing_pkg::cas_reset;
        end else if (wr_pend_q && addr_q == area_timing_pkg::area2_wait_control_off) begin
            cas_q <= hwdata[area_timing_pkg::cas_lsb +: 2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Area configuration register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            area_config_q <= area_timing_pkg::area_config_reset;
        end else if (wr_pend_q && addr_q == area_timing_pkg::area_config_off) begin
            area_config_q <= hwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shared SDRAM timing register; a single copy so the areas cannot drift apart
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sdram_timing_q <= area_timing_pkg::sdram_timing_reset;
        end else if (wr_pend_q && addr_q == area_timing_pkg::sdram_timing_off) begin
            sdram_timing_q <= hwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Area types and placement checks
    assign area2_type = area_timing_pkg::area_type_e'(area_config_q[area_timing_pkg::area2_type_lsb +: 2]);
    assign area3_type = area_timing_pkg::area_type_e'(area_config_q[area_timing_pkg::area3_type_lsb +: 2]);
    assign area2_sdram_en = (area2_type == area_timing_pkg::area_sdram);
    assign area3_sdram_en = (area3_type == area_timing_pkg::area_sdram);

    // Software is trusted to place a lone SDRAM in area 3; the flag only reports a slip
    assign placement_error = area2_sdram_en & ~area3_sdram_en;
    // With SDRAM only in area 3, area 2 must not be left at a reserved type
    assign area2_type_error = area3_sdram_en & (area2_type == area_timing_pkg::area_reserved);

    ////////////////////////////////////////////////////////////////////////////////
    // Effective timing: both SDRAM areas draw on the same fields
    always_comb begin
        shared_timing.precharge_wait = sdram_timing_q[area_timing_pkg::precharge_lsb +: 2];
        shared_timing.ras_to_cas_wait = sdram_timing_q[area_timing_pkg::ras_to_cas_lsb +: 2];
        shared_timing.write_precharge_wait = sdram_timing_q[area_timing_pkg::write_precharge_lsb +: 2];
        shared_timing.refresh_recovery_wait = sdram_timing_q[area_timing_pkg::refresh_recovery_lsb +: 2];
        // Reserved code 11 is held at three cycles rather than left undefined
        case (cas_q)
            2'h0: shared_timing.cas_latency_cycles = 2'h1;
            2'h1: shared_timing.cas_latency_cycles = 2'h2;
            default: shared_timing.cas_latency_cycles = 2'h3;
        endcase
    end

    // Non-SDRAM areas see zeros so the sequencer cannot act on stale values
    assign area3_timing = area3_sdram_en ? shared_timing : '0;
    assign area2_timing = area2_sdram_en ? shared_timing : '0;

    ////////////////////////////////////////////////////////////////////////////////
    // Read data multiplexer, driven through the data phase
    always_comb begin
        rd_word = 32'h0000_0000;                                           // Unmapped reads zero
        case (addr_q)
            area_timing_pkg::area2_wait_control_off: begin
                rd_word[area_timing_pkg::fixed_one_bit] = 1'b1;
                rd_word[area_timing_pkg::cas_lsb +: 2] = cas_q;             // Bits 9 and 31:11 stay zero; bit 10 reads one
            end
            area_timing_pkg::area_config_off: begin
                rd_word[7:0] = area_config_q;
            end
            area_timing_pkg::sdram_timing_off: begin
                rd_word[7:0] = sdram_timing_q;
            end
            area_timing_pkg::status_off: begin
                rd_word[area_timing_pkg::placement_error_bit] = placement_error;
                rd_word[area_timing_pkg::area2_type_error_bit] = area2_type_error;
                rd_word[area_timing_pkg::access_busy_bit] = (state_q != st_idle);
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    assign hrdata = rd_pend_q ? rd_word : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////////
    // Access engine: strobe for a fixed span, then the programmed hold
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= st_idle;
            strobe_cnt_q <= '0;
        end else begin
            case (state_q)
                st_idle: begin
                    if (access_req) begin
                        state_q <= st_strobe;
                        strobe_cnt_q <= strobe_last;
                    end
                end
                st_strobe: begin
                    if (strobe_cnt_q == '0) begin
                        // Strobe negates on this edge; hold window opens
                        state_q <= st_hold;
                    end else begin
                        strobe_cnt_q <= strobe_cnt_q - cnt_w'(1);
                    end
                end
                st_hold: begin
                    if (!hold_busy) begin
                        state_q <= st_idle;
                    end
                end
                default: begin
                    state_q <= st_idle;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Access attributes, latched when the request is taken
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            area_q <= 1'b0;
            write_q <= 1'b0;
            ext_addr <= '0;
        end else if (state_q == st_idle && access_req) begin
            area_q <= access_area;
            write_q <= access_write;
            ext_addr <= access_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Hold delay per area, chosen when the hold starts
    assign hold_code = area_q ? area_config_q[area_timing_pkg::area3_hold_lsb +: 2]
                              : area_config_q[area_timing_pkg::area2_hold_lsb +: 2];
    assign hold_start = (state_q == st_strobe) && (strobe_cnt_q == '0);

    strobe_hold_timer u_hold (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(hold_start),
        .hold_code(hold_code),
        .keep_q(hold_keep),
        .busy(hold_busy)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Pin drive: select and address live through strobe plus hold
    // Select is released by the falling-edge flop, which gives the half cycle
    assign ext_addr_valid = (state_q == st_strobe) | hold_keep;
    assign chip_select_n[0] = ~(ext_addr_valid & ~area_q);
    assign chip_select_n[1] = ~(ext_addr_valid & area_q);
    assign read_strobe_n = ~((state_q == st_strobe) & ~write_q);
    assign write_strobe_n = ~((state_q == st_strobe) & write_q);
    assign access_ack = (state_q == st_hold) & ~hold_busy;

endmodule

`default_nettype wire

/* rtl/strobe_hold_timer.sv */
// Hold timer: keeps address and chip select asserted n+0.5 cycles after strobe negation
`timescale 1ns/1ps
`default_nettype none

module strobe_hold_timer (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic start,          // High in the last strobe cycle
    input wire logic [1:0] hold_code,
    output logic keep_q,             // Falling-edge flop; low releases the select
    output logic busy
);

    logic pend_q;                    // Hold window in progress
    logic [1:0] cnt_q;               // Whole cycles still to wait

    ////////////////////////////////////////////////////////////////////////////////
    // Whole-cycle part of the delay, counted on rising edges
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_q <= 1'b0;
            cnt_q <= 2'h0;
        end else if (start) begin
            // Load on the edge where the strobe negates
            pend_q <= 1'b1;
            cnt_q <= hold_code;
        end else if (pend_q && cnt_q != 2'h0) begin
            cnt_q <= cnt_q - 2'h1;
        end else begin
            pend_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Half-cycle part: release on the falling edge after the count runs out
    // The start term covers the falling edge before strobe negation, so no gap opens
    always_ff @(negedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            keep_q <= 1'b0;
        end else begin
            keep_q <= start | (pend_q & (cnt_q != 2'h0));
        end
    end

    // Busy until both halves have finished
    assign busy = pend_q | keep_q;

endmodule

`default_nettype wire

/* tb/ext_mem_model.sv */
// Partner: passive external memory that times select release against strobe negation
`timescale 1ns/1ps
`default_nettype none

module ext_mem_model (
    input wire logic [1:0] chip_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [23:0] ext_addr,
    output var real hold_ns,
    output logic [1:0] last_cs,
    output logic [23:0] last_addr,
    output logic last_write
);
    realtime t_neg; // Time of the last strobe negation
    wire logic strobe_off;
    assign strobe_off = read_strobe_n & write_strobe_n;

    // Direction is taken when a strobe starts, before it can be released
    always @(negedge write_strobe_n) last_write = 1'b1;
    always @(negedge read_strobe_n) last_write = 1'b0;

    // Address and select are sampled at strobe end, the point the memory latches
    always @(posedge strobe_off) begin
        t_neg = $realtime;
        last_cs = chip_select_n;
        last_addr = ext_addr;
    end

    // Measured address and select hold after the strobe goes away
    always @(posedge (&chip_select_n)) hold_ns = $realtime - t_neg;
endmodule

`default_nettype wire

/* tb/sdram_area_timing_monitor.sv */
// Checker: register read-back, shared SDRAM timing and hold-delay pin properties
`timescale 1ns/1ps
`default_nettype none

module sdram_area_timing_monitor (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic access_ack,
    input wire logic ext_addr_valid,
    input wire logic [1:0] chip_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic area2_sdram_en,
    input wire logic area3_sdram_en,
    input wire area_timing_pkg::sdram_timing_s area2_timing,
    input wire area_timing_pkg::sdram_timing_s area3_timing
);
    logic ph_q, rd_q, wr_q, area_q; // Data phase flags, last selected area (1 is area 3)
    logic [7:0] a_q, cfg_q, tim_q;  // Captured offset and mirrored registers
    logic [1:0] cas_q, cyc, hold_c;
    logic sel_on, strobe_off;
    assign sel_on = !(&chip_select_n);
    assign strobe_off = read_strobe_n & write_strobe_n;
    assign cyc = (cas_q == 2'h0) ? 2'h1 : (cas_q == 2'h1) ? 2'h2 : 2'h3;
    // Hold code of the area whose select was last active
    assign hold_c = area_q ? cfg_q[7:6] : cfg_q[5:4];

    ////////////////////////////////////////////////////////////////////////////////
    // Address phase capture; the data phase follows one cycle later
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_q <= 1'b0;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            a_q <= 8'h00;
        end else begin
            ph_q <= hsel && hready && htrans[1];
            rd_q <= !hwrite;
            wr_q <= hwrite && (hsize == area_timing_pkg::hsize_word);
            a_q <= haddr[7:0];
        end
    end

    // Mirror of the writable fields, so expectations never come from the design
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cas_q <= area_timing_pkg::cas_reset;
            cfg_q <= 8'h00;
            tim_q <= 8'h00;
        end else if (ph_q && wr_q) begin
            if (a_q == area_timing_pkg::area2_wait_control_off) cas_q <= hwdata[8:7];
            if (a_q == area_timing_pkg::area_config_off) cfg_q <= hwdata[7:0];
            if (a_q == area_timing_pkg::sdram_timing_off) tim_q <= hwdata[7:0];
        end
    end

    // Remember which area the current or last access used
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) area_q <= 1'b0;
        else if (sel_on) area_q <= !chip_select_n[1];
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    shared_copy_a: assert property (area2_sdram_en && area3_sdram_en |-> area2_timing == area3_timing)
        else $error("area timings differ while both areas are SDRAM");
    area3_timing_a: assert property (area3_sdram_en |->
        area3_timing == {tim_q[1:0], tim_q[3:2], tim_q[5:4], tim_q[7:6], cyc})
        else $error("area 3 timing does not follow shared copy and CAS code");
    idle_timing_a: assert property (!area2_sdram_en |-> area2_timing == '0)
        else $error("area 2 timing not zero outside SDRAM mode");
    fixed_bits_a: assert property (ph_q && rd_q && a_q == 8'h00 |-> hrdata[31:11] == '0 && hrdata[10])
        else $error("wait control fixed bits read wrong");
    cas_readback_a: assert property (ph_q && rd_q && a_q == 8'h00 |-> hrdata[8:7] == cas_q)
        else $error("CAS code read back differs from last write");
    hold_min_a: assert property ($rose(strobe_off) && hold_c == 2'h0 |-> !sel_on)
        else $error("select not released half a cycle after strobe");
    hold_max_a: assert property ($rose(strobe_off) && hold_c == 2'h3 |-> sel_on [*3] ##1 !sel_on)
        else $error("select hold for code 3 wrong");
    addr_select_a: assert property (!strobe_off |-> sel_on && ext_addr_valid)
        else $error("strobe active without select and address");
    ack_release_a: assert property ($fell(sel_on) |-> ##[0:2] access_ack)
        else $error("no acknowledge after select release");

    cover property (area2_sdram_en && area3_sdram_en);
    cover property ($rose(strobe_off) && hold_c == 2'h3);
    cover property (access_ack && area_q);
endmodule

bind sdram_area_timing_config sdram_area_timing_monitor u_mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .access_ack(access_ack), .ext_addr_valid(ext_addr_valid), .chip_select_n(chip_select_n),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .area2_sdram_en(area2_sdram_en),
    .area3_sdram_en(area3_sdram_en), .area2_timing(area2_timing), .area3_timing(area3_timing));

`default_nettype wire

/* tb/tb_sdram_area_timing_config.sv */
// Testbench: register map, CAS latency, shared timing and hold-delay scenarios
`timescale 1ns/1ps
`default_nettype none

module tb_sdram_area_timing_config;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
    logic [1:0] htrans = '0, cs_n, last_cs;
    logic [2:0] hsize = '0;
    logic access_req = 0, access_area = 0, access_write = 0, access_ack;
    logic [23:0] access_addr = '0, ext_addr, last_addr;
    logic addr_valid, rd_n, wr_n, a2_en, a3_en, last_write;
    area_timing_pkg::sdram_timing_s a2_t, a3_t;
    real hold_ns;
    int n_errors = 0, compares = 0, cycles = 0;
    wire logic hready; // Single slave: its ready is the bus ready
    assign hready = hreadyout;

    sdram_area_timing_config u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .access_req(access_req),
        .access_area(access_area), .access_write(access_write), .access_addr(access_addr),
        .access_ack(access_ack), .ext_addr(ext_addr), .ext_addr_valid(addr_valid), .chip_select_n(cs_n),
        .read_strobe_n(rd_n), .write_strobe_n(wr_n), .area2_sdram_en(a2_en), .area3_sdram_en(a3_en),
        .area2_timing(a2_t), .area3_timing(a3_t));
    ext_mem_model u_mem (.chip_select_n(cs_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
        .ext_addr(ext_addr), .hold_ns(hold_ns), .last_cs(last_cs), .last_addr(last_addr),
        .last_write(last_write));

    always #12.5 hclk = ~hclk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // One AHB single word transfer; waits on ready in both phases
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= area_timing_pkg::hsize_word;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        ahb(1'b0, a, 32'h0000_0000);
        check(r, exp, what);
        check({31'h0, hresp}, 32'h0000_0000, "response not okay");
    endtask

    // External access; request held until the acknowledge is sampled at a rising edge
    task automatic access(input logic area, input logic w, input logic [23:0] a);
        @(posedge hclk);
        access_req <= 1'b1;
        access_area <= area;
        access_write <= w;
        access_addr <= a;
        do @(posedge hclk); while (access_ack !== 1'b1);
        access_req <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        rd_chk(8'h00, 32'h0000_0500, "wait control reset");
        rd_chk(8'h04, 32'h0000_0000, "hold code reset");
        ahb(1'b1, 8'h10, 32'hffff_ffff);
        rd_chk(8'h10, 32'h0000_0000, "unmapped read");
        rd_chk(8'h00, 32'h0000_0500, "after unmapped write");
    endtask

    // Single SDRAM area placed in area 3 with area 2 as byte SRAM
    task automatic t_cas;
        ahb(1'b1, 8'h04, 32'h0000_0009);
        // Code 11 is reserved and is expected to behave as three cycles
        for (int c = 0; c < 4; c++) begin
            ahb(1'b1, 8'h00, 32'h0000_0400 | (c << 7));
            rd_chk(8'h00, 32'h0000_0400 | (c << 7), "CAS read back");
            check({30'h0, a3_t.cas_latency_cycles}, 32'((c == 3) ? 3 : c + 1), "CAS cycles");
        end
        check({30'h0, a2_en, a3_en}, 32'h0000_0001, "single SDRAM area");
        ahb(1'b1, 8'h00, 32'h0000_0500);
    endtask

    task automatic t_shared;
        ahb(1'b1, 8'h08, 32'h0000_00e4);
        ahb(1'b1, 8'h04, 32'h0000_000a);
        @(negedge hclk);
        check({22'h0, a2_t}, 32'h0000_006f, "area 2 shared timing");
        check({22'h0, a3_t}, 32'h0000_006f, "area 3 shared timing");
        ahb(1'b1, 8'h04, 32'h0000_0009);
        @(negedge hclk);
        check({22'h0, a2_t}, 32'h0000_0000, "area 2 timing off");
        check({22'h0, a3_t}, 32'h0000_006f, "area 3 timing kept");
        // Deliberate slips, so the status flags are seen to rise
        ahb(1'b1, 8'h04, 32'h0000_0002);
        rd_chk(8'h0c, 32'h0000_0001, "lone SDRAM in area 2 flag");
        ahb(1'b1, 8'h04, 32'h0000_000b);
        rd_chk(8'h0c, 32'h0000_0002, "reserved area 2 type flag");
    endtask

    // Every hold code in both areas, alternating read and write
    task automatic t_hold;
        for (int area = 0; area < 2; area++) begin
            for (int code = 0; code < 4; code++) begin
                ahb(1'b1, 8'h04, 32'(code << (area ? 6 : 4)));
                access(area[0], code[0], 24'h00_1230 + 24'(code));
                check(32'($rtoi(hold_ns * 10.0)), 32'((2 * code + 1) * 125), "hold time");
                check({30'h0, last_cs}, area ? 32'h0000_0001 : 32'h0000_0002, "select used");
                check({8'h00, last_addr}, 32'h0000_1230 + 32'(code), "address");
                check({31'h0, last_write}, 32'(code[0]), "direction");
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Cuts a hang short; the whole run needs well under a thousand cycles
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            end_sim;
        end
    end

    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs;
        t_cas;
        t_shared;
        t_hold;
        end_sim;
    end
endmodule

`default_nettype wire
